// *** core/fsts_pkg.sv ***
// Purpose: Shared constants and types for the failsafe I/O test stop sequencer
// Assumes: 25 MHz system clock, one sampling tick per safety sampling period
// Notes: Times are in microseconds; cycle counts derive from the clock rate
package fsts_pkg;
    localparam int unsigned FSTS_CLK_HZ = 25000000;
    localparam int unsigned FSTS_NUM_IN = 10;
    localparam int unsigned FSTS_NUM_OUT = 4;
    localparam int unsigned FSTS_NUM_COMM = 6;
    localparam int unsigned FSTS_TW = 24;
    // Fixed least wait in the input phase
    localparam int unsigned FSTS_IN_WAIT_US = 20000;
    localparam int unsigned FSTS_US_CYC = FSTS_CLK_HZ / 1000000;
    localparam logic [23:0] FSTS_IN_WAIT_CYC = 24'(FSTS_IN_WAIT_US * FSTS_US_CYC);
    // Input bits checked in each input step
    localparam logic [9:0] FSTS_IN_GRP_A = 10'h01f;
    localparam logic [9:0] FSTS_IN_GRP_B = 10'h3e0;
    // Output switch pattern per step: {high side, low side}
    localparam logic [9:0] FSTS_SW_PAT = {2'b00, 2'b11, 2'b01, 2'b10, 2'b00};
    // Expected response per step, step 0 in bit 4
    localparam logic [4:0] FSTS_EXP_M1 = 5'b00010;
    localparam logic [4:0] FSTS_EXP_M2 = 5'b10001;
    localparam logic [4:0] FSTS_EXP_M3 = 5'b10111;
    localparam logic [1:0] FSTS_MODE_1 = 2'h0;
    localparam logic [1:0] FSTS_MODE_2 = 2'h1;
    localparam logic [1:0] FSTS_MODE_3 = 2'h2;
    localparam logic [7:0] FSTS_FAULT_NONE = 8'h00;
    localparam logic [7:0] FSTS_FAULT_IN_BASE = 8'h01;
    localparam logic [7:0] FSTS_FAULT_OUT_BASE = 8'h10;
    typedef enum logic [2:0] {
        FSTS_IDLE, FSTS_IN_STEP, FSTS_IN_WAIT, FSTS_OUT_STEP, FSTS_OUT_WAIT, FSTS_DONE
    } fsts_state_e;
endpackage

// *** core/fsts_timer.sv ***
// Purpose: Interval timer that counts sampling ticks down to zero
// Assumes: Load has priority over counting
// Notes: expired_o is a level, held until the next load
`timescale 1ns/1ns
module fsts_timer import fsts_pkg::*; #(
    parameter int unsigned W = 32
) (
    input wire logic mclk_i, // System clock
    input wire logic rst_n_i, // Async reset, active low
    input wire logic ce_i, // Clock enable
    input wire logic load_i, // Restart the interval
    input wire logic tick_i, // Sampling tick
    input wire logic [W-1:0] period_i, // Interval in ticks
    output logic expired_o // Interval elapsed
);
    logic [W-1:0] cnt_reg;
    logic run_reg;
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg <= '0;
            run_reg <= 1'b0;
            expired_o <= 1'b0;
        end else if (ce_i) begin
            if (load_i) begin
                cnt_reg <= period_i;
                run_reg <= 1'b1;
                expired_o <= 1'b0;
            end else if (run_reg && tick_i) begin
                if (cnt_reg <= W'(1)) begin
                    run_reg <= 1'b0;
                    expired_o <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg - W'(1);
                end
            end
        end
    end
endmodule // fsts_timer

// *** core/fsts_sequencer.sv ***
// Purpose: Test stop sequencer for ten failsafe inputs and four failsafe outputs
// Assumes: All inputs synchronous to mclk_i; times given in clock cycles, test interval in sampling ticks
// Notes: Fault code names the failing step; outputs come from flip-flops
`timescale 1ns/1ns
module fsts_sequencer import fsts_pkg::*; #(
    parameter int unsigned TW = FSTS_TW,
    parameter int unsigned IW = 32,
    parameter int unsigned IN_WAIT_CYC = FSTS_IN_WAIT_CYC
) (
    input wire logic mclk_i, // System clock, 25 MHz
    input wire logic rst_n_i, // Async reset, active low
    input wire logic ce_i, // Clock enable
    input wire logic test_trigger_source_i, // Start request, rising edge
    input wire logic auto_power_on_test_bit_i, // Start after power-on
    input wire logic [IW-1:0] test_interval_timer_i, // Interval in ticks
    input wire logic [3:0] output_feedback_enable_mask_i, // Outputs under test
    input wire logic [7:0] output_test_mode_select_i, // Mode per output, 2 bits
    input wire logic [9:0] input_test_select_mask_i, // Inputs under test
    input wire logic [TW-1:0] feedback_wait_time_i, // Feedback wait, cycles
    input wire logic [TW-1:0] input_debounce_time_i, // Debounce, cycles
    input wire logic [6*TW-1:0] comm_sampling_times_i, // Six sampling times, cycles
    input wire logic [9:0] failsafe_input_i, // Raw failsafe inputs
    input wire logic [3:0] feedback_in_i, // Feedback inputs 20 to 23
    input wire logic [3:0] diagnostic_feedback_i, // Output diagnostic lines
    input wire logic [3:0] output_cmd_i, // Normal output commands
    output logic [9:0] failsafe_value_o, // Inputs to safety logic
    output logic [3:0] out_high_o, // High-side switches
    output logic [3:0] out_low_o, // Low-side switches
    output logic first_sensor_supply_o, // Sensor supply 1 on
    output logic second_sensor_supply_o, // Sensor supply 2 on
    output logic test_due_alarm_o, // Test due
    output logic test_active_alarm_o, // Test running
    output logic test_fault_o, // Test fault present
    output logic [7:0] test_fault_value_o, // Failing step code
    output logic [TW-1:0] safety_sampling_period_o, // Current sampling period
    output logic tick_o // Sampling tick pulse
);
    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    function automatic logic [TW-1:0] max3(input logic [TW-1:0] a, input logic [TW-1:0] b,
                                           input logic [TW-1:0] c);
        logic [TW-1:0] m;
        m = (a > b) ? a : b;
        return (m > c) ? m : c;
    endfunction

    function automatic logic exp_bit(input logic [1:0] mode, input logic [2:0] step);
        logic [4:0] t;
        t = (mode == FSTS_MODE_1) ? FSTS_EXP_M1 :
            (mode == FSTS_MODE_2) ? FSTS_EXP_M2 : FSTS_EXP_M3;
        return t[3'd4 - step];
    endfunction

    // ------------------------------------------------------------
    // Sampling period and tick
    // ------------------------------------------------------------
    logic [TW-1:0] min_period;
    always_comb begin
        min_period = comm_sampling_times_i[TW-1:0];
        for (int i = 1; i < FSTS_NUM_COMM; i++) begin
            if (comm_sampling_times_i[i*TW +: TW] < min_period) begin
                min_period = comm_sampling_times_i[i*TW +: TW];
            end
        end
    end
    wire [TW-1:0] period_eff = (min_period == '0) ? TW'(1) : min_period;

    logic [TW-1:0] tick_cnt_reg;
    wire tick_now = (tick_cnt_reg >= period_eff - TW'(1));
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tick_cnt_reg <= '0;
            tick_o <= 1'b0;
            safety_sampling_period_o <= '0;
        end else if (ce_i) begin
            tick_cnt_reg <= tick_now ? '0 : tick_cnt_reg + TW'(1);
            tick_o <= tick_now;
            safety_sampling_period_o <= period_eff;
        end
    end

    // ------------------------------------------------------------
    // Input debounce
    // ------------------------------------------------------------
    logic [9:0] deb_reg;
    logic [9:0] raw_prev_reg;
    logic [TW-1:0] deb_cnt_reg;
    wire raw_changed = (failsafe_input_i != raw_prev_reg);
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            deb_reg <= '0;
            raw_prev_reg <= '0;
            deb_cnt_reg <= '0;
        end else if (ce_i) begin
            raw_prev_reg <= failsafe_input_i;
            if (raw_changed) begin
                deb_cnt_reg <= '0;
            end else if (deb_cnt_reg >= input_debounce_time_i) begin
                deb_reg <= failsafe_input_i;
            end else begin
                deb_cnt_reg <= deb_cnt_reg + TW'(1);
            end
        end
    end

    // ------------------------------------------------------------
    // Waits and start requests
    // ------------------------------------------------------------
    wire [TW-1:0] in_wait = max3(TW'(IN_WAIT_CYC), period_eff, input_debounce_time_i);
    wire [TW-1:0] out_wait = max3(feedback_wait_time_i, period_eff, input_debounce_time_i);

    logic trig_prev_reg;
    logic por_pend_reg;
    wire trig_rise = test_trigger_source_i && !trig_prev_reg;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    fsts_state_e state_reg;
    logic [2:0] step_reg;
    logic [TW-1:0] wait_reg;
    logic [7:0] fault_next;
    logic run_ok_reg;
    logic timer_load_reg;
    logic timer_expired;

    wire [9:0] in_grp = (step_reg == 3'd0) ? FSTS_IN_GRP_A : FSTS_IN_GRP_B;
    wire in_bad = |(deb_reg & in_grp & input_test_select_mask_i);
    wire [1:0] sw_pair = FSTS_SW_PAT[(3'd4 - step_reg) * 2 +: 2];

    logic [3:0] resp_bad;
    always_comb begin
        for (int o = 0; o < FSTS_NUM_OUT; o++) begin
            logic [1:0] md;
            logic seen;
            md = output_test_mode_select_i[o*2 +: 2];
            seen = (md == FSTS_MODE_1) ? diagnostic_feedback_i[o] : feedback_in_i[o];
            resp_bad[o] = output_feedback_enable_mask_i[o] && (seen != exp_bit(md, step_reg));
        end
    end
    wire out_bad = |resp_bad;
    wire wait_done = (wait_reg == '0);
    wire start_req = trig_rise || por_pend_reg;
    assign fault_next = (state_reg == FSTS_IN_WAIT) ? FSTS_FAULT_IN_BASE + 8'(step_reg) :
                        FSTS_FAULT_OUT_BASE + 8'(step_reg);

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= FSTS_IDLE;
            step_reg <= '0;
            wait_reg <= '0;
            run_ok_reg <= 1'b0;
            trig_prev_reg <= 1'b0;
            por_pend_reg <= 1'b0;
            timer_load_reg <= 1'b0;
            test_fault_o <= 1'b0;
            test_fault_value_o <= FSTS_FAULT_NONE;
        end else if (ce_i) begin
            trig_prev_reg <= test_trigger_source_i;
            timer_load_reg <= 1'b0;
            if (!run_ok_reg) begin
                run_ok_reg <= 1'b1;
                por_pend_reg <= auto_power_on_test_bit_i;
            end
            unique case (state_reg)
                FSTS_IDLE: begin
                    if (start_req && run_ok_reg) begin
                        por_pend_reg <= 1'b0;
                        step_reg <= '0;
                        test_fault_o <= 1'b0;
                        test_fault_value_o <= FSTS_FAULT_NONE;
                        state_reg <= FSTS_IN_STEP;
                    end
                end
                FSTS_IN_STEP: begin
                    if (tick_o) begin
                        wait_reg <= in_wait;
                        state_reg <= FSTS_IN_WAIT;
                    end
                end
                FSTS_IN_WAIT: begin
                    if (!wait_done) begin
                        wait_reg <= wait_reg - TW'(1);
                    end else if (in_bad) begin
                        test_fault_o <= 1'b1;
                        test_fault_value_o <= fault_next;
                        state_reg <= FSTS_DONE;
                    end else if (step_reg == 3'd1) begin
                        step_reg <= '0;
                        state_reg <= FSTS_OUT_STEP;
                    end else begin
                        step_reg <= step_reg + 3'd1;
                        state_reg <= FSTS_IN_STEP;
                    end
                end
                FSTS_OUT_STEP: begin
                    if (tick_o) begin
                        wait_reg <= out_wait;
                        state_reg <= FSTS_OUT_WAIT;
                    end
                end
                FSTS_OUT_WAIT: begin
                    if (!wait_done) begin
                        wait_reg <= wait_reg - TW'(1);
                    end else if (out_bad) begin
                        test_fault_o <= 1'b1;
                        test_fault_value_o <= fault_next;
                        state_reg <= FSTS_DONE;
                    end else if (step_reg == 3'd4) begin
                        timer_load_reg <= 1'b1;
                        state_reg <= FSTS_DONE;
                    end else begin
                        step_reg <= step_reg + 3'd1;
                        state_reg <= FSTS_OUT_STEP;
                    end
                end
                FSTS_DONE: begin
                    step_reg <= '0;
                    state_reg <= FSTS_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Interval timer
    // ------------------------------------------------------------
    fsts_timer #(.W(IW)) u_timer (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .load_i(timer_load_reg),
        .tick_i(tick_o),
        .period_i(test_interval_timer_i),
        .expired_o(timer_expired)
    );

    // ------------------------------------------------------------
    // Outputs and alarms
    // ------------------------------------------------------------
    wire running = (state_reg != FSTS_IDLE) && (state_reg != FSTS_DONE);
    wire in_phase = (state_reg == FSTS_IN_STEP) || (state_reg == FSTS_IN_WAIT);
    wire out_phase = (state_reg == FSTS_OUT_STEP) || (state_reg == FSTS_OUT_WAIT);
    wire mode1_all = (output_test_mode_select_i[1:0] == FSTS_MODE_1);
    wire sup1_next = !(in_phase && (step_reg == 3'd0 || mode1_all));
    wire sup2_next = !(in_phase && step_reg == 3'd1 && mode1_all);
    wire [3:0] hi_next = running ?
        (out_phase ? (output_feedback_enable_mask_i & {4{sw_pair[1]}}) : 4'h0) : output_cmd_i;
    wire [3:0] lo_next = running ?
        (out_phase ? (output_feedback_enable_mask_i & {4{sw_pair[0]}}) : 4'h0) : output_cmd_i;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            failsafe_value_o <= '0;
            out_high_o <= '0;
            out_low_o <= '0;
            first_sensor_supply_o <= 1'b1;
            second_sensor_supply_o <= 1'b1;
            test_due_alarm_o <= 1'b1;
            test_active_alarm_o <= 1'b0;
        end else if (ce_i) begin
            if (!running) begin
                failsafe_value_o <= deb_reg;
            end
            out_high_o <= hi_next;
            out_low_o <= lo_next;
            first_sensor_supply_o <= sup1_next;
            second_sensor_supply_o <= sup2_next;
            if (state_reg == FSTS_DONE) begin
                test_active_alarm_o <= 1'b0;
                test_due_alarm_o <= test_fault_o;
            end else begin
                test_active_alarm_o <= running;
                if (timer_expired) begin
                    test_due_alarm_o <= 1'b1;
                end
            end
        end
    end
endmodule // fsts_sequencer

// *** verif/fsts_checker.sv ***
// Purpose: Port assertions for the failsafe I/O test stop sequencer
// Assumes: One clock domain; configuration inputs held steady by the bench within each run
// Notes: Bound to every fsts_sequencer instance
`timescale 1ns/1ns
module fsts_checker import fsts_pkg::*; #(
    parameter int unsigned TW = FSTS_TW
) (
    input wire logic mclk_i, // System clock
    input wire logic rst_n_i, // Async reset, active low
    input wire logic ce_i, // Clock enable
    input wire logic test_trigger_source_i, // Start request
    input wire logic [3:0] output_feedback_enable_mask_i, // Outputs under test
    input wire logic [7:0] output_test_mode_select_i, // Mode per output
    input wire logic [6*TW-1:0] comm_sampling_times_i, // Six sampling times
    input wire logic [3:0] output_cmd_i, // Normal output commands
    input wire logic [9:0] failsafe_value_o, // Inputs to safety logic
    input wire logic [3:0] out_high_o, // High-side switches
    input wire logic [3:0] out_low_o, // Low-side switches
    input wire logic first_sensor_supply_o, // Sensor supply 1
    input wire logic second_sensor_supply_o, // Sensor supply 2
    input wire logic test_due_alarm_o, // Test due
    input wire logic test_active_alarm_o, // Test running
    input wire logic test_fault_o, // Test fault
    input wire logic [7:0] test_fault_value_o, // Failing step code
    input wire logic [TW-1:0] safety_sampling_period_o, // Sampling period
    input wire logic tick_o // Sampling tick
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    logic [TW-1:0] gap_reg;
    logic seen_reg;
    logic [TW-1:0] min_w;
    always_comb begin
        min_w = comm_sampling_times_i[TW-1:0];
        for (int i = 1; i < 6; i++) begin
            if (comm_sampling_times_i[i*TW +: TW] < min_w) begin
                min_w = comm_sampling_times_i[i*TW +: TW];
            end
        end
    end
    // Cycles since the previous tick
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gap_reg <= '0;
            seen_reg <= 1'b0;
        end else if (ce_i && tick_o) begin
            gap_reg <= '0;
            seen_reg <= 1'b1;
        end else if (ce_i) begin
            gap_reg <= gap_reg + 1'b1;
        end
    end
    sequence s_quiet;
        !test_active_alarm_o [*5];
    endsequence
    sequence s_start;
        $rose(test_trigger_source_i) && !test_active_alarm_o;
    endsequence
    property p_tick;
        ce_i && tick_o && seen_reg |-> gap_reg == safety_sampling_period_o - 1'b1;
    endproperty
    property p_period;
        $stable(comm_sampling_times_i) [*3] |-> safety_sampling_period_o == min_w;
    endproperty
    property p_start;
        s_start |-> ##2 test_active_alarm_o;
    endproperty
    property p_end;
        $fell(test_active_alarm_o) |-> test_fault_o == test_due_alarm_o;
    endproperty
    property p_due;
        $fell(test_due_alarm_o) |-> $fell(test_active_alarm_o);
    endproperty
    property p_freeze;
        test_active_alarm_o && $past(test_active_alarm_o) |-> $stable(failsafe_value_o);
    endproperty
    property p_mask;
        test_active_alarm_o |->
            ((out_high_o | out_low_o) & ~output_feedback_enable_mask_i) == 4'h0;
    endproperty
    property p_supply;
        $rose(test_active_alarm_o) |-> !first_sensor_supply_o && second_sensor_supply_o;
    endproperty
    property p_step2;
        $fell(second_sensor_supply_o) |->
            !first_sensor_supply_o && output_test_mode_select_i[1:0] == FSTS_MODE_1;
    endproperty
    property p_fault;
        $rose(test_fault_o) |-> test_active_alarm_o
            && (test_fault_value_o inside {8'h01, 8'h02, [8'h10:8'h14]});
    endproperty
    property p_idle;
        s_quiet |-> $past(out_high_o, 3) == $past(output_cmd_i, 4)
            && $past(out_low_o, 3) == $past(output_cmd_i, 4);
    endproperty
    a_tick: assert property (p_tick) else $error("tick spacing differs from period");
    a_period: assert property (p_period) else $error("period is not the minimum");
    a_start: assert property (p_start) else $error("run did not start on trigger");
    a_end: assert property (p_end) else $error("alarms wrong at end of run");
    a_due: assert property (p_due) else $error("due alarm cleared outside run end");
    a_freeze: assert property (p_freeze) else $error("input values moved during run");
    a_mask: assert property (p_mask) else $error("unmasked output driven in run");
    a_supply: assert property (p_supply) else $error("supplies wrong in first step");
    a_step2: assert property (p_step2) else $error("supply 2 off outside mode 1");
    a_fault: assert property (p_fault) else $error("bad fault code");
    a_idle: assert property (p_idle) else $error("idle outputs differ from commands");
endmodule // fsts_checker
bind fsts_sequencer fsts_checker #(.TW(TW)) i_fsts_checker (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .test_trigger_source_i(test_trigger_source_i),
    .output_feedback_enable_mask_i(output_feedback_enable_mask_i),
    .output_test_mode_select_i(output_test_mode_select_i),
    .comm_sampling_times_i(comm_sampling_times_i), .output_cmd_i(output_cmd_i),
    .failsafe_value_o(failsafe_value_o), .out_high_o(out_high_o), .out_low_o(out_low_o),
    .first_sensor_supply_o(first_sensor_supply_o),
    .second_sensor_supply_o(second_sensor_supply_o), .test_due_alarm_o(test_due_alarm_o),
    .test_active_alarm_o(test_active_alarm_o), .test_fault_o(test_fault_o),
    .test_fault_value_o(test_fault_value_o),
    .safety_sampling_period_o(safety_sampling_period_o), .tick_o(tick_o));

// *** verif/fsts_far_side.sv ***
// Purpose: Model of output circuits, sensors and feedback wiring
// Assumes: Circuit kind per output follows the mode selection
// Notes: Responses arrive LAG cycles late; an unwired feedback line toggles
`timescale 1ns/1ns
module fsts_far_side import fsts_pkg::*; #(
    parameter int unsigned LAG = 6
) (
    input wire logic mclk_i, // System clock
    input wire logic [3:0] out_high_i, // High-side switches
    input wire logic [3:0] out_low_i, // Low-side switches
    input wire logic [7:0] mode_i, // Circuit kind per output
    input wire logic first_supply_i, // Sensor supply 1 on
    input wire logic second_supply_i, // Sensor supply 2 on
    input wire logic [9:0] sensor_i, // Sensor contacts closed
    input wire logic [9:0] short_i, // Sensor lines shorted high
    output logic [9:0] failsafe_input_o, // To failsafe inputs
    output logic [3:0] feedback_o, // To feedback inputs
    output logic [3:0] diagnostic_o // To diagnostic lines
);
    logic [3:0] fb_w;
    logic [3:0] dg_w;
    logic [3:0] fb_pipe [LAG];
    logic [3:0] dg_pipe [LAG];
    logic [3:0] float_reg = 4'h5;
    always_comb begin
        for (int j = 0; j < 4; j++) begin
            dg_w[j] = out_high_i[j] & ~out_low_i[j];
            case (mode_i[2*j +: 2])
                2'h0: fb_w[j] = float_reg[j];
                2'h1: fb_w[j] = ~out_high_i[j] & ~out_low_i[j];
                default: fb_w[j] = ~(out_high_i[j] & out_low_i[j]);
            endcase
        end
    end
    always_ff @(posedge mclk_i) begin
        float_reg <= ~float_reg;
        fb_pipe[0] <= fb_w;
        dg_pipe[0] <= dg_w;
        for (int k = 1; k < LAG; k++) begin
            fb_pipe[k] <= fb_pipe[k-1];
            dg_pipe[k] <= dg_pipe[k-1];
        end
    end
    assign feedback_o = fb_pipe[LAG-1];
    assign diagnostic_o = dg_pipe[LAG-1];
    // A dead supply leaves the line at 0 V; a short holds it high
    assign failsafe_input_o[4:0] = (sensor_i[4:0] & {5{first_supply_i}}) | short_i[4:0];
    assign failsafe_input_o[9:5] = (sensor_i[9:5] & {5{second_supply_i}}) | short_i[9:5];
endmodule // fsts_far_side

// *** verif/failsafe_io_test_stop_sequencer_test.sv ***
// Purpose: Self-checking bench for the test stop sequencer
// Assumes: Power-on run first, then a triggered run with a shorted input
// Notes: Fixed input wait is shortened by parameter so each run takes a few hundred cycles
`timescale 1ns/1ns
module failsafe_io_test_stop_sequencer_test import fsts_pkg::*;;
    localparam int unsigned TW = FSTS_TW;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic trig = 1'b0;
    logic [7:0] mode_sel = 8'hb4;
    logic ce = 1'b1;
    logic [3:0] fb_en = 4'h7;
    logic [9:0] in_mask = 10'h2ff;
    logic [TW-1:0] fb_wait, debounce, period, exp_p;
    logic [6*TW-1:0] comm;
    logic [9:0] sens, short_l, fs_in, fs_val, exp_fs;
    logic [3:0] fb, dg, cmd, hi, lo;
    logic sup1, sup2, due, act, flt, tick;
    logic [7:0] flt_val;
    int bad_count = 0;
    int checked = 0;
    int cyc = 0;
    int n;
    fsts_sequencer #(.TW(TW), .IW(32), .IN_WAIT_CYC(200)) i_fsts_sequencer (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce), .test_trigger_source_i(trig),
        .auto_power_on_test_bit_i(1'b1), .test_interval_timer_i(32'h4),
        .output_feedback_enable_mask_i(fb_en), .output_test_mode_select_i(mode_sel),
        .input_test_select_mask_i(in_mask), .feedback_wait_time_i(fb_wait),
        .input_debounce_time_i(debounce), .comm_sampling_times_i(comm),
        .failsafe_input_i(fs_in), .feedback_in_i(fb), .diagnostic_feedback_i(dg),
        .output_cmd_i(cmd), .failsafe_value_o(fs_val), .out_high_o(hi), .out_low_o(lo),
        .first_sensor_supply_o(sup1), .second_sensor_supply_o(sup2),
        .test_due_alarm_o(due), .test_active_alarm_o(act), .test_fault_o(flt),
        .test_fault_value_o(flt_val), .safety_sampling_period_o(period), .tick_o(tick));
    fsts_far_side #(.LAG(6)) i_fsts_far_side (
        .mclk_i(mclk_i), .out_high_i(hi), .out_low_i(lo), .mode_i(mode_sel),
        .first_supply_i(sup1), .second_supply_i(sup2), .sensor_i(sens), .short_i(short_l),
        .failsafe_input_o(fs_in), .feedback_o(fb), .diagnostic_o(dg));
    function automatic logic [TW-1:0] min6(input logic [6*TW-1:0] c);
        logic [TW-1:0] m;
        m = c[TW-1:0];
        for (int i = 1; i < 6; i++) begin
            if (c[i*TW +: TW] < m) begin
                m = c[i*TW +: TW];
            end
        end
        return m;
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic wait_act(input logic lvl);
        n = 0;
        while (act !== lvl && n < 5000) begin
            @(posedge mclk_i);
            n++;
        end
        check(n < 5000, 1'b1);
        #1;
    endtask
    initial begin
        forever #20 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            test_done();
        end
    end
    initial begin
        void'($urandom(20708));
        fb_wait = TW'($urandom_range(40, 8));
        debounce = TW'($urandom_range(8, 1));
        for (int i = 0; i < 6; i++) begin
            comm[i*TW +: TW] = TW'($urandom_range(60, 20));
        end
        sens = 10'($urandom);
        short_l = 10'h100;
        cmd = 4'($urandom) | 4'h8;
        exp_p = min6(comm);
        repeat (3) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        @(posedge mclk_i);
        #1;
        check(due, 1'b1);
        repeat (3) @(posedge mclk_i);
        #1;
        check(act, 1'b1);
        check(period, exp_p);
        wait_act(1'b0);
        check(flt, 1'b0);
        check(due, 1'b0);
        n = 0;
        while (due !== 1'b1 && n < 1000) begin
            @(posedge mclk_i);
            n++;
        end
        check(n >= 3 * exp_p && n <= 5 * exp_p + 4, 1'b1);
        @(posedge mclk_i);
        mode_sel <= 8'hb5;
        short_l <= 10'h080;
        cmd <= 4'($urandom);
        repeat (200) @(posedge mclk_i);
        exp_fs = sens | short_l;
        check(fs_val, exp_fs);
        ce <= 1'b0;
        sens <= ~sens;
        repeat (20) @(posedge mclk_i);
        check(fs_val, exp_fs);
        ce <= 1'b1;
        sens <= ~sens;
        trig <= 1'b1;
        repeat (4) @(posedge mclk_i);
        #1;
        check(act, 1'b1);
        @(posedge mclk_i);
        sens <= 10'h000;
        trig <= 1'b0;
        repeat (2) @(posedge mclk_i);
        trig <= 1'b1;
        repeat (100) @(posedge mclk_i);
        #1;
        check(fs_val, exp_fs);
        wait_act(1'b0);
        check(flt, 1'b1);
        check(flt_val, 8'h02);
        check(due, 1'b1);
        test_done();
    end
endmodule // failsafe_io_test_stop_sequencer_test
